//--- pdcl_regs.svh
// Register offsets, field positions and constants of the PLL config loader
`ifndef PDCL_REGS_SVH
`define PDCL_REGS_SVH
`define PDCL_CFG_W 81
`define PDCL_CFG_RST 81'h0
`define PDCL_CNT_W 7
`define PDCL_CNT_FULL 7'h51
`define PDCL_CNT_ZERO 7'h00
`define PDCL_CNT_ONE 7'h01
`define PDCL_ADDR_W 8
`define PDCL_DATA_W 32
`define PDCL_DATA_ZERO 32'h0
`define PDCL_OFS_CTRL 8'h00
`define PDCL_OFS_STAT 8'h04
`define PDCL_OFS_ACT0 8'h08
`define PDCL_OFS_ACT1 8'h0c
`define PDCL_OFS_ACT2 8'h10
`define PDCL_CTRL_RST 3'h0
`define PDCL_CTRL_SRC 0
`define PDCL_CTRL_APPLY 1
`define PDCL_CTRL_LOCK 2
`define PDCL_STAT_SHORT 0
`define PDCL_STAT_FULL 1
`define PDCL_STAT_STATE 2
`define PDCL_STAT_CNT 4
`define PDCL_STAT_APPLIES 16
`define PDCL_APPLY_CNT_W 8
`define PDCL_APPLY_CNT_ONE 8'h01
`define PDCL_APPLY_CNT_RST 8'h00
`define PDCL_DIV_W 7
`define PDCL_ODIV_W 5
`define PDCL_DLY_W 5
`define PDCL_F_INDIV 0
`define PDCL_F_FBDIV 7
`define PDCL_F_ODIV_U 14
`define PDCL_F_ODIV_V 19
`define PDCL_F_ODIV_W 24
`define PDCL_F_FBDLY 29
`define PDCL_F_SYSBYP 34
`define PDCL_F_FBBYP 35
`define PDCL_F_SEC1DLY 36
`define PDCL_F_SEC2DLY 41
`define PDCL_F_GADLY 46
`define PDCL_F_GBDLY 51
`define PDCL_F_GCDLY 56
`define PDCL_DLY_MIN_PS 600
`define PDCL_DLY_MAX_PS 5560
`define PDCL_DLY_STEP_PS 160
`define PDCL_EDGE_N 4
`define PDCL_E_SCLK 0
`define PDCL_E_STROBE 1
`define PDCL_E_TCK 2
`define PDCL_E_TUPD 3
`endif

//--- pdcl_pkg.sv
// Types shared by the PLL config loader
package pdcl_pkg;
  // Gray order along idle, shift, full, apply
  typedef enum logic [1:0] {
    pdcl_st_idle = 2'h0,
    pdcl_st_shift = 2'h1,
    pdcl_st_full = 2'h3,
    pdcl_st_apply = 2'h2
  } pdcl_state_t;
  typedef enum logic {
    pdcl_src_fabric = 1'h0,
    pdcl_src_tap = 1'h1
  } pdcl_src_t;
endpackage : pdcl_pkg

//--- pdcl_edge_det.sv
// Rising edge detector for slow control levels sampled on the system clock
`timescale 1ns/1ps
module pdcl_edge_det #(
  parameter int N = 4
) (
  input logic i_ref_clk, // System clock
  input logic i_nrst, // Async reset, active low
  input logic [N-1:0] i_level, // Levels to watch
  output logic [N-1:0] o_rise // One-cycle pulse per rising edge
);
  logic [N-1:0] prev_reg;

  // One history flop per input; inputs are already synchronous
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_edge
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          prev_reg[g] <= 1'b0;
        end else begin
          prev_reg[g] <= i_level[g];
        end
      end
      assign o_rise[g] = i_level[g] & ~prev_reg[g];
    end
  endgenerate
endmodule : pdcl_edge_det

//--- pdcl_shift_reg.sv
// Serial configuration shift register, LSB first in and out
`timescale 1ns/1ps
module pdcl_shift_reg #(
  parameter int W = 81
) (
  input logic i_ref_clk, // System clock
  input logic i_nrst, // Async reset, active low
  input logic i_shift, // One-cycle shift request
  input logic i_din, // Serial bit entering at the top
  output logic [W-1:0] o_q // Register contents
);
  // New bit enters at the top so the first bit loaded ends in bit 0
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_q <= '0;
    end else if (i_shift) begin
      o_q <= {i_din, o_q[W-1:1]};
    end
  end

  a_shift_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !i_shift |=> $stable(o_q))
    else $error("shift register changed without a shift");
  a_shift_move: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    i_shift |=> (o_q[W-1] == $past(i_din))
    && (o_q[W-2:0] == $past(o_q[W-1:1])))
    else $error("shift register did not move by one bit");
endmodule : pdcl_shift_reg

//--- pdcl_loader.sv
// Dynamic configuration loader of the PLL clock conditioning block
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "pdcl_regs.svh"
module pdcl_loader (
  input logic i_ref_clk, // 40 MHz system clock
  input logic i_nrst, // Async reset, active low
  input logic i_serial_config_in, // Fabric serial data, LSB first
  input logic i_shift_clock, // Fabric shift clock level
  input logic i_config_shift_enable, // Fabric shift enable, high active
  input logic i_config_apply_strobe, // Fabric apply strobe
  input logic i_tap_tck, // Test port shift clock level
  input logic i_tap_tdi, // Test port serial data
  input logic i_tap_shift, // Test port shift enable
  input logic i_tap_update, // Test port apply strobe
  input logic [`PDCL_ADDR_W-1:0] i_addr, // Register byte address
  input logic [`PDCL_DATA_W-1:0] i_wdata, // Register write data
  input logic i_wr, // Write strobe
  input logic i_rd, // Read strobe
  output logic [`PDCL_DATA_W-1:0] o_rdata, // Read data, cycle after i_rd
  output logic o_serial_config_out, // Serial readback to fabric
  output logic o_tap_tdo, // Serial readback to test port
  output logic o_apply_pulse, // One-cycle pulse in the same cycle a new setting lands
  output logic [`PDCL_DIV_W-1:0] o_in_div, // Input divider code, factor-1
  output logic [`PDCL_DIV_W-1:0] o_fb_div, // Feedback divider code
  output logic [`PDCL_ODIV_W-1:0] o_out_div_u, // Primary output divider
  output logic [`PDCL_ODIV_W-1:0] o_out_div_v, // Secondary 1 divider
  output logic [`PDCL_ODIV_W-1:0] o_out_div_w, // Secondary 2 divider
  output logic [`PDCL_DLY_W-1:0] o_fb_delay_sel, // Feedback delay step
  output logic o_sys_delay_bypass, // Bypass fixed system delay
  output logic o_fb_delay_bypass, // Bypass feedback delay
  output logic [`PDCL_DLY_W-1:0] o_sec1_core_delay, // Secondary 1 core
  output logic [`PDCL_DLY_W-1:0] o_sec2_core_delay, // Secondary 2 core
  output logic [`PDCL_DLY_W-1:0] o_glb_delay_a, // Primary global delay
  output logic [`PDCL_DLY_W-1:0] o_glb_delay_b, // Secondary 1 global
  output logic [`PDCL_DLY_W-1:0] o_glb_delay_c // Secondary 2 global
);
  // Number of delay steps; a 5-bit field must cover every one of them
  localparam int DLY_STEPS =
    (`PDCL_DLY_MAX_PS - `PDCL_DLY_MIN_PS) / `PDCL_DLY_STEP_PS;

  pdcl_pkg::pdcl_state_t state_reg;
  pdcl_pkg::pdcl_state_t state_next;
  logic [2:0] ctrl_reg;
  logic [`PDCL_CNT_W-1:0] bit_cnt_reg;
  logic [`PDCL_APPLY_CNT_W-1:0] apply_cnt_reg;
  logic short_reg;
  logic [`PDCL_CFG_W-1:0] active_reg;
  logic [`PDCL_CFG_W-1:0] shift_q;
  logic [`PDCL_EDGE_N-1:0] levels;
  logic [`PDCL_EDGE_N-1:0] rise;
  logic src_tap;
  logic shift_edge;
  logic shift_din;
  logic update_edge;
  logic cur_enable;
  logic soft_apply;
  logic apply;
  logic wr_ctrl;
  logic wr_stat;
  logic short_clr;
  logic [`PDCL_DATA_W-1:0] rd_mux;
  logic [`PDCL_DATA_W-1:0] stat_word;

  // Word of the active setting seen at a given register address
  function automatic logic [`PDCL_DATA_W-1:0] act_word(
    input logic [`PDCL_ADDR_W-1:0] addr,
    input logic [`PDCL_CFG_W-1:0] cfg
  );
    logic [`PDCL_DATA_W-1:0] w;
    w = `PDCL_DATA_ZERO;
    case (addr)
      `PDCL_OFS_ACT0: w = cfg[31:0];
      `PDCL_OFS_ACT1: w = cfg[63:32];
      `PDCL_OFS_ACT2: w = {15'h0, cfg[80:64]};
      default: w = `PDCL_DATA_ZERO;
    endcase
    return w;
  endfunction : act_word

  // Edges of both loading ports are tracked at all times, so switching
  // the source never fakes an edge on the newly chosen port
  assign levels = {i_tap_update, i_tap_tck,
                   i_config_apply_strobe, i_shift_clock};

  pdcl_edge_det #(
    .N(`PDCL_EDGE_N)
  ) u_edge (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_level(levels),
    .o_rise(rise)
  );

  // Source choice between fabric serial port and test access port
  assign src_tap = (ctrl_reg[`PDCL_CTRL_SRC] == pdcl_pkg::pdcl_src_tap);
  assign cur_enable = src_tap ? i_tap_shift : i_config_shift_enable;
  assign shift_din = src_tap ? i_tap_tdi : i_serial_config_in;
  // Shift only on a rising shift clock with enable high
  assign shift_edge = cur_enable & (src_tap ? rise[`PDCL_E_TCK]
                                            : rise[`PDCL_E_SCLK]);
  assign update_edge = src_tap ? rise[`PDCL_E_TUPD]
                               : rise[`PDCL_E_STROBE];

  // Apply is refused while a shift is enabled or software holds the lock
  assign soft_apply = wr_ctrl & i_wdata[`PDCL_CTRL_APPLY];
  assign apply = (update_edge | soft_apply) & ~cur_enable
                 & ~ctrl_reg[`PDCL_CTRL_LOCK];

  pdcl_shift_reg #(
    .W(`PDCL_CFG_W)
  ) u_shift (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_shift(shift_edge),
    .i_din(shift_din),
    .o_q(shift_q)
  );

  // Register decode
  assign wr_ctrl = i_wr & (i_addr == `PDCL_OFS_CTRL);
  assign wr_stat = i_wr & (i_addr == `PDCL_OFS_STAT);
  assign short_clr = wr_stat & i_wdata[`PDCL_STAT_SHORT];

  // Control register; the apply bit is a pulse and is not stored
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= `PDCL_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg[`PDCL_CTRL_SRC] <= i_wdata[`PDCL_CTRL_SRC];
      ctrl_reg[`PDCL_CTRL_LOCK] <= i_wdata[`PDCL_CTRL_LOCK];
      ctrl_reg[`PDCL_CTRL_APPLY] <= 1'b0;
    end
  end

  // Load progress state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pdcl_pkg::pdcl_st_idle: begin
        if (apply) begin
          state_next = pdcl_pkg::pdcl_st_apply;
        end else if (shift_edge) begin
          state_next = pdcl_pkg::pdcl_st_shift;
        end
      end
      pdcl_pkg::pdcl_st_shift: begin
        if (apply) begin
          state_next = pdcl_pkg::pdcl_st_apply;
        end else if (shift_edge &&
                     bit_cnt_reg == `PDCL_CNT_FULL - `PDCL_CNT_ONE) begin
          state_next = pdcl_pkg::pdcl_st_full;
        end
      end
      pdcl_pkg::pdcl_st_full: begin
        if (apply) begin
          state_next = pdcl_pkg::pdcl_st_apply;
        end
      end
      pdcl_pkg::pdcl_st_apply: begin
        state_next = shift_edge ? pdcl_pkg::pdcl_st_shift
                                : pdcl_pkg::pdcl_st_idle;
      end
      default: state_next = pdcl_pkg::pdcl_st_idle;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= pdcl_pkg::pdcl_st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bits shifted since the last apply, saturating at a full word
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_cnt_reg <= `PDCL_CNT_ZERO;
    end else if (apply) begin
      bit_cnt_reg <= `PDCL_CNT_ZERO;
    end else if (shift_edge && bit_cnt_reg != `PDCL_CNT_FULL) begin
      bit_cnt_reg <= bit_cnt_reg + `PDCL_CNT_ONE;
    end
  end

  // Sticky flag for an apply on a partial word; a new event beats a clear
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      short_reg <= 1'b0;
    end else if (apply && bit_cnt_reg != `PDCL_CNT_FULL) begin
      short_reg <= 1'b1;
    end else if (short_clr) begin
      short_reg <= 1'b0;
    end
  end

  // Apply count wraps; software compares successive reads
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      apply_cnt_reg <= `PDCL_APPLY_CNT_RST;
    end else if (apply) begin
      apply_cnt_reg <= apply_cnt_reg + `PDCL_APPLY_CNT_ONE;
    end
  end

  // Whole word moves in one edge so the PLL never sees a mixed setting
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      active_reg <= `PDCL_CFG_RST;
      o_apply_pulse <= 1'b0;
    end else begin
      o_apply_pulse <= apply;
      if (apply) begin
        active_reg <= shift_q;
      end
    end
  end

  // Serial readback of bit 0; each shift exposes the next bit
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_serial_config_out <= 1'b0;
      o_tap_tdo <= 1'b0;
    end else begin
      o_serial_config_out <= shift_q[0];
      o_tap_tdo <= shift_q[0];
    end
  end

  // Read data stand only in the cycle after the strobe
  assign stat_word = {8'h0, apply_cnt_reg, 5'h0, bit_cnt_reg,
                      state_reg, (bit_cnt_reg == `PDCL_CNT_FULL),
                      short_reg};
  always_comb begin
    rd_mux = act_word(i_addr, active_reg);
    if (i_addr == `PDCL_OFS_CTRL) begin
      rd_mux = {29'h0, ctrl_reg};
    end else if (i_addr == `PDCL_OFS_STAT) begin
      rd_mux = stat_word;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= `PDCL_DATA_ZERO;
    end else begin
      o_rdata <= i_rd ? rd_mux : `PDCL_DATA_ZERO;
    end
  end

  // Shared dividers and per-output dividers and delays of the active word
  assign o_in_div = active_reg[`PDCL_F_INDIV +: `PDCL_DIV_W];
  assign o_fb_div = active_reg[`PDCL_F_FBDIV +: `PDCL_DIV_W];
  assign o_out_div_u = active_reg[`PDCL_F_ODIV_U +: `PDCL_ODIV_W];
  assign o_out_div_v = active_reg[`PDCL_F_ODIV_V +: `PDCL_ODIV_W];
  assign o_out_div_w = active_reg[`PDCL_F_ODIV_W +: `PDCL_ODIV_W];
  assign o_fb_delay_sel = active_reg[`PDCL_F_FBDLY +: `PDCL_DLY_W];
  assign o_sys_delay_bypass = active_reg[`PDCL_F_SYSBYP];
  assign o_fb_delay_bypass = active_reg[`PDCL_F_FBBYP];
  assign o_sec1_core_delay =
    active_reg[`PDCL_F_SEC1DLY +: `PDCL_DLY_W];
  assign o_sec2_core_delay =
    active_reg[`PDCL_F_SEC2DLY +: `PDCL_DLY_W];
  assign o_glb_delay_a = active_reg[`PDCL_F_GADLY +: `PDCL_DLY_W];
  assign o_glb_delay_b = active_reg[`PDCL_F_GBDLY +: `PDCL_DLY_W];
  assign o_glb_delay_c = active_reg[`PDCL_F_GCDLY +: `PDCL_DLY_W];

  // Checks next to the logic they guard
  sequence s_apply;
    apply;
  endsequence
  sequence s_fabric_blocked;
    !src_tap && rise[`PDCL_E_SCLK] && !i_config_shift_enable;
  endsequence
  // A refused request must leave no trace, not even a pulse
  sequence s_apply_refused;
    (update_edge || soft_apply)
    && (cur_enable || ctrl_reg[`PDCL_CTRL_LOCK]);
  endsequence

  a_apply_load: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    s_apply |=> active_reg == $past(shift_q) && o_apply_pulse)
    else $error("apply did not load the shifted word");
  a_apply_refused: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    s_apply_refused |=> !o_apply_pulse && $stable(active_reg))
    else $error("refused apply changed the setting");
  a_no_partial: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !apply |=> $stable(active_reg))
    else $error("active setting changed without apply");
  a_sdo_follow: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    shift_edge |=> ##1 o_serial_config_out == $past(shift_q[1], 2))
    else $error("serial output did not show next bit");
  a_enable_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    s_fabric_blocked |=> $stable(shift_q))
    else $error("shift occurred with enable low");
  a_tap_path: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    src_tap && rise[`PDCL_E_TCK] && i_tap_shift
    |=> shift_q[`PDCL_CFG_W-1] == $past(i_tap_tdi))
    else $error("test port bit not shifted in");
  a_count_step: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    shift_edge && bit_cnt_reg != `PDCL_CNT_FULL
    |=> bit_cnt_reg == $past(bit_cnt_reg) + `PDCL_CNT_ONE)
    else $error("bit count did not step with a shift");
  a_count_full: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    shift_edge && !apply && bit_cnt_reg == `PDCL_CNT_FULL - `PDCL_CNT_ONE
    |=> state_reg == pdcl_pkg::pdcl_st_full
        && bit_cnt_reg == `PDCL_CNT_FULL)
    else $error("full word not recognised at 81 bits");
  a_short_sticky: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    s_apply ##0 bit_cnt_reg != `PDCL_CNT_FULL |=> short_reg [*2])
    else $error("partial apply flag not set or not held");
  a_read_window: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !i_rd |=> o_rdata == `PDCL_DATA_ZERO)
    else $error("read data outside its cycle");
  a_delay_range: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (1 << `PDCL_DLY_W) == DLY_STEPS + 1)
    else $error("delay field does not match step count");
endmodule : pdcl_loader

//--- pdcl_fab_loader.sv
// Behavioural loading party on one serial configuration port
`timescale 1ns/1ps
module pdcl_fab_loader (
  input wire logic i_ref_clk, // System clock
  output logic o_sclk, // Shift clock, still outside frames
  output logic o_sdata, // Serial data, LSB first
  output logic o_shift_en, // Shift enable, high active
  output logic o_strobe // Apply strobe
);
  // Quiet lines until the first frame
  initial begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_shift_en = 1'b0;
    o_strobe = 1'b0;
  end

  // Data held one cycle past the falling clock, so a late sampler still
  // sees the bit; slow stretches both clock phases
  task automatic load(input logic [80:0] w, input int n, input bit slow,
                      input bit en);
    for (int i = 0; i < n; i++) begin
      o_shift_en <= en;
      o_sdata <= w[i];
      repeat (slow ? 3 : 1) @(posedge i_ref_clk);
      o_sclk <= 1'b1;
      repeat (slow ? 2 : 1) @(posedge i_ref_clk);
      o_sclk <= 1'b0;
      @(posedge i_ref_clk);
    end
    o_shift_en <= 1'b0;
    o_sdata <= ~w[n-1]; // Released line must not keep the last bit
    repeat (2) @(posedge i_ref_clk);
  endtask : load

  // Apply strobe; en high here makes a request that must be dropped
  task automatic apply(input bit en);
    o_shift_en <= en;
    @(posedge i_ref_clk);
    o_strobe <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    o_strobe <= 1'b0;
    o_shift_en <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask : apply
endmodule : pdcl_fab_loader

//--- tb_pll_dynamic_config_loader.sv
// Self-checking bench of the PLL configuration loader
`timescale 1ns/1ps
`include "pdcl_regs.svh"
module tb_pll_dynamic_config_loader;
  logic i_ref_clk, i_nrst, i_wr, i_rd;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, rdata, seed, m_ctrl;
  logic sdi, sclk, sen, sup, tdi, tck, tsh, tup, sdo, tdo, pulse;
  logic [6:0] ind, fbv;
  logic [4:0] du, dv, dw, fbd, s1, s2, ga, gb, gc;
  logic sbyp, fbyp;
  logic [60:0] fields;
  logic [80:0] m_sr, m_act, w;
  logic [95:0] r96;
  int m_cnt, m_apps, pulses, cycles, fails, comparisons;
  bit m_short;
  assign fields = {gc, gb, ga, s2, s1, fbyp, sbyp, fbd, dw, dv, du, fbv, ind};

  // Free-running 40 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  pdcl_loader DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_serial_config_in(sdi), .i_shift_clock(sclk),
    .i_config_shift_enable(sen), .i_config_apply_strobe(sup),
    .i_tap_tck(tck), .i_tap_tdi(tdi), .i_tap_shift(tsh),
    .i_tap_update(tup), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata), .o_serial_config_out(sdo),
    .o_tap_tdo(tdo), .o_apply_pulse(pulse), .o_in_div(ind), .o_fb_div(fbv),
    .o_out_div_u(du), .o_out_div_v(dv), .o_out_div_w(dw),
    .o_fb_delay_sel(fbd), .o_sys_delay_bypass(sbyp),
    .o_fb_delay_bypass(fbyp), .o_sec1_core_delay(s1),
    .o_sec2_core_delay(s2), .o_glb_delay_a(ga), .o_glb_delay_b(gb),
    .o_glb_delay_c(gc));
  pdcl_fab_loader fab (.i_ref_clk(i_ref_clk), .o_sclk(sclk),
    .o_sdata(sdi), .o_shift_en(sen), .o_strobe(sup));
  pdcl_fab_loader tap (.i_ref_clk(i_ref_clk), .o_sclk(tck),
    .o_sdata(tdi), .o_shift_en(tsh), .o_strobe(tup));

  // Pulse tally and hang guard; the ceiling is well above the planned run
  always @(posedge i_ref_clk) begin
    if (pulse === 1'b1) pulses++;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input string nm, input logic [80:0] e,
                     input logic [80:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Model shifts only with enable high, then the chosen port sends
  task automatic send(input bit on_tap, input int n, input bit slow,
                      input bit en);
    for (int i = 0; i < n; i++) if (en) begin
      m_sr = {w[i], m_sr[80:1]};
      m_cnt++;
    end
    if (on_tap) tap.load(w, n, slow, en);
    else fab.load(w, n, slow, en);
  endtask : send

  task automatic mapply();
    m_short = m_short | (m_cnt < 81);
    m_act = m_sr;
    m_cnt = 0;
    m_apps++;
  endtask : mapply

  task automatic do_apply(input bit on_tap, input bit en, input bit ok);
    if (ok) mapply();
    if (on_tap) tap.apply(en);
    else fab.apply(en);
  endtask : do_apply

  // Every visible result but the status state field against the model
  task automatic chk_all(input string t);
    logic [31:0] d;
    logic [31:0] st;
    repeat (3) @(posedge i_ref_clk);
    chk("fields", 81'(m_act[60:0]), 81'(fields));
    rd(`PDCL_OFS_ACT0, d);
    chk("act0", 81'(m_act[31:0]), 81'(d));
    rd(`PDCL_OFS_ACT1, d);
    chk("act1", 81'(m_act[63:32]), 81'(d));
    rd(`PDCL_OFS_ACT2, d);
    chk("act2", 81'(m_act[80:64]), 81'(d));
    rd(`PDCL_OFS_CTRL, d);
    chk("ctrl", 81'(m_ctrl), 81'(d));
    rd(8'h20, d);
    chk("unmapped", 81'h0, 81'(d));
    rd(`PDCL_OFS_STAT, d);
    st = {8'h0, m_apps[7:0], 5'h0, m_cnt[6:0], 2'h0, m_cnt == 81, m_short};
    chk("status", 81'(st), 81'(d & 32'h00ff07f3));
    @(posedge i_ref_clk);
    #1 chk("rdata_idle", 81'h0, 81'(rdata));
    chk("pulses", 81'(m_apps), 81'(pulses));
    chk("sdo", 81'(m_sr[0]), 81'(sdo));
    chk("tdo", 81'(m_sr[0]), 81'(tdo));
    $display("test %s done", t);
    @(posedge i_ref_clk); // Hand back on an edge so drivers change there
  endtask : chk_all

  task automatic rword();
    r96 = {xs(), xs(), xs()};
    w = r96[80:0];
  endtask : rword

  task automatic final_report();
    $display("counts comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    seed = 32'h3e;
    m_sr = 81'h0;
    m_act = 81'h0;
    m_ctrl = 32'h0;
    repeat (5) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    chk_all("reset");
    rword();
    send(0, 81, 0, 1);
    chk_all("full_load");
    do_apply(0, 0, 1);
    chk_all("strobe_apply");
    rword();
    send(0, 10, 1, 0);
    chk_all("enable_low");
    send(0, 5, 0, 1);
    wr(`PDCL_OFS_CTRL, 32'h2);
    mapply();
    wr(`PDCL_OFS_ACT0, xs());
    chk_all("short_apply");
    wr(`PDCL_OFS_STAT, 32'h1);
    m_short = 1'b0;
    m_ctrl = 32'h4;
    wr(`PDCL_OFS_CTRL, m_ctrl);
    rword();
    send(0, 81, 1, 1);
    do_apply(0, 0, 0);
    chk_all("locked");
    m_ctrl = 32'h0;
    wr(`PDCL_OFS_CTRL, m_ctrl);
    do_apply(0, 1, 0);
    chk_all("enable_high_apply");
    do_apply(0, 0, 1);
    chk_all("unlocked_apply");
    m_ctrl = 32'h1;
    wr(`PDCL_OFS_CTRL, m_ctrl);
    w = {81{1'b1}};
    send(1, 81, 1, 1);
    do_apply(0, 0, 0);
    do_apply(1, 0, 1);
    chk_all("tap_all_ones");
    w = 81'h0;
    send(1, 81, 0, 1);
    do_apply(1, 0, 1);
    chk_all("tap_all_zeros");
    m_ctrl = 32'h0;
    wr(`PDCL_OFS_CTRL, m_ctrl);
    for (int k = 0; k < 3; k++) begin
      rword();
      send(0, 81, seed[0], 1);
      do_apply(0, 0, 1);
      chk_all("random");
    end
    final_report();
  end
endmodule : tb_pll_dynamic_config_loader
